// [verilog/sfid_params.svh]
// Constants of the SPI FIFO, interrupt-source and DMA-trigger block
// How it works
// RQ1: Every slave-select output has its own polarity, active low by default.
// RQ2: Frame-pulse precede/coincide sub-modes invert the generated select polarity.
// RQ3: FIFOs hold 8 words of 16 bits, or 16 bytes in byte mode; the receive path adds a 2-entry output stage.
// RQ4: Software keeps frame widths at eight bits or fewer in byte mode.
// RQ5: Interrupt output asserts when any enabled source is active.
// RQ6: Receive DMA request uses the receive-level comparison.
// RQ7: Transmit DMA request uses the transmit-level comparison.
// RQ8: Master done sets once the last transmit element has shifted out.
// RQ9: Done precedes the last receive completion by one serial clock.
// RQ10: Transmit-empty is a level, active once the last element leaves.
// RQ11: Transmit-not-full is a level, active while one more element fits.
// RQ12: Transmit overflow sets on a write to a full transmit FIFO.
// RQ13: Underflow is a level in master mode, an event in slave mode.
// RQ14: Transmit level active while entry count is below the threshold.
// RQ15: Bus error sets when select drops in the middle of a frame.
// RQ16: Receive not-empty and full are levels of the receive FIFO.
// RQ17: Receive overflow sets on a hardware write into a full FIFO.
// RQ18: Receive underflow sets on a software read of an empty FIFO.
// RQ19: Receive level active while entry count exceeds the threshold.
// RQ20: Writing one clears a source; unchanged levels set again at once.
// RQ21: Event sources latch until software writes one to clear them.
// RQ22: Interrupt is the OR of every source ANDed with its enable.
`ifndef SFID_PARAMS_SVH
`define SFID_PARAMS_SVH

`define SFID_NSRC 12
`define SFID_SRC_DONE 0
`define SFID_SRC_TX_NOT_FULL 1
`define SFID_SRC_TX_EMPTY 2
`define SFID_SRC_TX_OVF 3
`define SFID_SRC_TX_UDF 4
`define SFID_SRC_TX_LVL 5
`define SFID_SRC_BUS_ERR 6
`define SFID_SRC_RX_NOT_EMPTY 7
`define SFID_SRC_RX_FULL 8
`define SFID_SRC_RX_OVF 9
`define SFID_SRC_RX_UDF 10
`define SFID_SRC_RX_LVL 11

`define SFID_SRC_RST 12'h000
`define SFID_SS_RST 4'hF
`define SFID_WORD_DEPTH 8
`define SFID_BYTE_DEPTH 16
`define SFID_OUT_DEPTH 2
`define SFID_DATA_W 16
`define SFID_BYTE_W 8

`endif

// [verilog/sfid_pkg.sv]
// Types shared by the SPI FIFO, interrupt-source and DMA-trigger block
`include "sfid_params.svh"
package sfid_pkg;
  typedef logic [`SFID_NSRC-1:0] sfid_src_type;
  typedef enum logic [1:0] {
    SF_IDLE = 2'b01,
    SF_SEL = 2'b10
  } sfid_frame_type;
endpackage

// [verilog/sfid_fifo_if.sv]
// Valid/ready carrier between a FIFO and the logic that fills and drains it
`timescale 1ns/1ps
`default_nettype none
interface sfid_fifo_if #(
  parameter int W = 16,
  parameter int CW = 5
);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic [CW-1:0] count;
  logic [CW-1:0] cap;
  modport store (
    input wr_valid, wr_data, rd_ready, cap,
    output wr_ready, rd_valid, rd_data, count
  );
  modport user (
    output wr_valid, wr_data, rd_ready, cap,
    input wr_ready, rd_valid, rd_data, count
  );
endinterface
`default_nettype wire

// [verilog/sfid_fifo.sv]
// Circular FIFO with a run-time capacity limit at or below its array depth
`timescale 1ns/1ps
`default_nettype none
module sfid_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_b_i, // Synchronous reset, active low
  sfid_fifo_if.store f // Fill and drain sides
);
  import sfid_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || CW < $clog2(DEPTH + 1))
    $error("sfid_fifo: DEPTH must be a power of two of at least 2");

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic push;
  logic pop;

  // Capacity below DEPTH still wraps cleanly: pointers run mod DEPTH
  assign f.wr_ready = count_ff < f.cap;
  assign f.rd_valid = count_ff != '0;
  assign f.rd_data = mem[rd_ptr_ff];
  assign f.count = count_ff;
  assign push = f.wr_valid & f.wr_ready;
  assign pop = f.rd_valid & f.rd_ready;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= f.wr_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      count_ff <= count_ff + CW'(push) - CW'(pop);
    end
  end

  AST_CAP_LIMIT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RQ3
    count_ff <= f.cap || $past(count_ff) > f.cap)
    else $error("FIFO holds more entries than its capacity");
endmodule
`default_nettype wire

// [verilog/sfid_top.sv]
// SPI FIFOs, interrupt sources, DMA triggers and slave-select polarity
`timescale 1ns/1ps
`default_nettype none
`include "sfid_params.svh"
module sfid_top #(
  parameter int WORD_DEPTH = `SFID_WORD_DEPTH,
  parameter int BYTE_DEPTH = `SFID_BYTE_DEPTH,
  parameter int CW = $clog2(`SFID_BYTE_DEPTH + 1)
) (
  input wire logic clk_sys_i, // System clock, 50 MHz
  input wire logic rst_b_i, // Synchronous reset, active low
  input wire logic master_mode_i, // 1 master, 0 slave
  input wire logic byte_mode_i, // 1 selects 8-bit wide, double-depth FIFOs
  input wire logic ti_precede_i, // Frame-pulse precede/coincide sub-mode
  input wire logic cpol_i, // Idle level of the serial clock
  input wire logic [3:0] ss_polarity_i, // Per line: 1 active high
  input wire logic [4:0] frame_bits_i, // Frame width, 4 to 16
  input wire logic [3:0] ss_active_i, // Shifter wants each line selected
  output logic [3:0] slave_select_lines_o, // Select pins, master mode
  input wire logic spi_sclk_i, // Serial clock pin, slave mode
  input wire logic spi_ss_i, // Select pin, slave mode
  input wire logic tx_wr_valid_i, // Software writes a transmit element
  input wire logic [15:0] tx_wr_data_i, // Transmit element
  output logic tx_rd_valid_o, // Transmit element ready for the shifter
  output logic [15:0] tx_rd_data_o, // Head of the transmit FIFO
  input wire logic tx_rd_ready_i, // Shifter takes the head element
  input wire logic shift_busy_i, // Shifter holds an element in progress
  input wire logic rx_wr_valid_i, // Shifter delivers a received element
  input wire logic [15:0] rx_wr_data_i, // Received element
  output logic rx_rd_valid_o, // Received element available to software
  output logic [15:0] rx_rd_data_o, // Oldest received element
  input wire logic rx_rd_ready_i, // Software reads a received element
  input wire logic [CW-1:0] tx_level_i, // Transmit threshold
  input wire logic [CW-1:0] rx_level_i, // Receive threshold
  input wire logic [11:0] irq_en_i, // Source enables
  input wire logic [11:0] src_clr_i, // Write-one-to-clear strobes
  output logic [11:0] src_status_o, // Source bits
  output logic irq_o, // Interrupt, active high
  output logic tx_dma_request_o, // Transmit DMA trigger
  output logic rx_dma_request_o // Receive DMA trigger
);
  import sfid_pkg::*;

  if (BYTE_DEPTH != 2 * WORD_DEPTH || CW != $clog2(BYTE_DEPTH + 1))
    $error("sfid_top: BYTE_DEPTH must be twice WORD_DEPTH");

  logic [CW-1:0] cap;
  logic [15:0] tx_in;
  logic [15:0] rx_in;
  logic tx_empty;
  logic rx_full;

  sfid_fifo_if #(.W(`SFID_DATA_W), .CW(CW)) tx_if ();
  sfid_fifo_if #(.W(`SFID_DATA_W), .CW(CW)) rx_if ();
  sfid_fifo_if #(.W(`SFID_DATA_W), .CW(CW)) rxb_if ();

  // Byte mode trades width for depth; change it only while the FIFOs are idle
  assign cap = byte_mode_i ? CW'(BYTE_DEPTH) : CW'(WORD_DEPTH); // RQ3
  // Upper byte is dropped in byte mode; frames must fit eight bits
  assign tx_in = byte_mode_i ? {8'h00, tx_wr_data_i[7:0]} : tx_wr_data_i; // RQ4
  assign rx_in = byte_mode_i ? {8'h00, rx_wr_data_i[7:0]} : rx_wr_data_i;

  assign tx_if.wr_valid = tx_wr_valid_i;
  assign tx_if.wr_data = tx_in;
  assign tx_if.rd_ready = tx_rd_ready_i;
  assign tx_if.cap = cap;
  assign tx_rd_valid_o = tx_if.rd_valid;
  assign tx_rd_data_o = tx_if.rd_data;

  assign rx_if.wr_valid = rx_wr_valid_i;
  assign rx_if.wr_data = rx_in;
  assign rx_if.rd_ready = rxb_if.wr_ready;
  assign rx_if.cap = cap;

  // Output stage absorbs a stalled reader; the FIFO behind it then fills
  assign rxb_if.wr_valid = rx_if.rd_valid;
  assign rxb_if.wr_data = rx_if.rd_data;
  assign rxb_if.rd_ready = rx_rd_ready_i;
  assign rxb_if.cap = CW'(`SFID_OUT_DEPTH);
  assign rx_rd_valid_o = rxb_if.rd_valid;
  assign rx_rd_data_o = rxb_if.rd_data;

  sfid_fifo #(.WIDTH(`SFID_DATA_W), .DEPTH(BYTE_DEPTH), .CW(CW)) u_tx_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .f(tx_if.store)
  );

  sfid_fifo #(.WIDTH(`SFID_DATA_W), .DEPTH(BYTE_DEPTH), .CW(CW)) u_rx_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .f(rx_if.store)
  );

  sfid_fifo #(.WIDTH(`SFID_DATA_W), .DEPTH(`SFID_OUT_DEPTH), .CW(CW)) u_rx_out (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .f(rxb_if.store)
  );

  assign tx_empty = tx_if.count == '0;
  assign rx_full = rx_if.count == cap;

  // Slave-select outputs
  logic [3:0] nxt_ss;
  assign nxt_ss = ss_active_i ^ ~ss_polarity_i ^ {4{ti_precede_i}}; // RQ1 RQ2

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      slave_select_lines_o <= `SFID_SS_RST;
    end else begin
      slave_select_lines_o <= nxt_ss;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  logic sclk_meta_ff;
  logic sclk_sync_ff;
  logic sclk_prev_ff;
  logic ss_meta_ff;
  logic ss_sync_ff;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sclk_meta_ff <= 1'b0;
      sclk_sync_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      ss_meta_ff <= 1'b1;
      ss_sync_ff <= 1'b1;
    end else begin
      sclk_meta_ff <= spi_sclk_i;
      sclk_sync_ff <= sclk_meta_ff;
      sclk_prev_ff <= sclk_sync_ff;
      ss_meta_ff <= spi_ss_i;
      ss_sync_ff <= ss_meta_ff;
    end
  end

  // Slave frame tracking on the sampled serial clock
  logic lead_edge;
  logic ss_sel;
  logic slave_udf_evt;
  logic bus_err_evt;
  sfid_frame_type frame_ff;
  logic [4:0] bitcnt_ff;

  assign lead_edge = (sclk_sync_ff != sclk_prev_ff) && (sclk_sync_ff != cpol_i);
  assign ss_sel = ss_sync_ff ~^ ss_polarity_i[0];
  assign bus_err_evt = (frame_ff == SF_SEL) && !ss_sel &&
                       (bitcnt_ff != 5'h00); // RQ15
  assign slave_udf_evt = (frame_ff == SF_SEL) && ss_sel && lead_edge &&
                         (bitcnt_ff == 5'h00) && tx_empty; // RQ13

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      frame_ff <= SF_IDLE;
      bitcnt_ff <= 5'h00;
    end else begin
      case (frame_ff)
        SF_IDLE: begin
          bitcnt_ff <= 5'h00;
          if (!master_mode_i && ss_sel) begin
            frame_ff <= SF_SEL;
          end
        end
        SF_SEL: begin
          if (master_mode_i || !ss_sel) begin
            frame_ff <= SF_IDLE;
          end else if (lead_edge) begin
            if (bitcnt_ff >= frame_bits_i - 5'h01) begin
              bitcnt_ff <= 5'h00;
            end else begin
              bitcnt_ff <= bitcnt_ff + 5'h01;
            end
          end
        end
        default: begin
          frame_ff <= SF_IDLE;
        end
      endcase
    end
  end

  // Master done: the shifter goes idle with nothing left in the FIFO.
  // The shifter reports idle one serial clock before the last receive ends.
  logic busy_prev_ff;
  logic done_evt;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      busy_prev_ff <= 1'b0;
    end else begin
      busy_prev_ff <= shift_busy_i;
    end
  end

  assign done_evt = master_mode_i && busy_prev_ff && !shift_busy_i &&
                    tx_empty; // RQ8 RQ9

  // Interrupt sources
  sfid_src_type src_set;
  sfid_src_type src_ff;
  sfid_src_type nxt_src;

  always_comb begin
    src_set = `SFID_SRC_RST;
    src_set[`SFID_SRC_DONE] = done_evt;
    src_set[`SFID_SRC_TX_NOT_FULL] = tx_if.count < cap; // RQ11
    src_set[`SFID_SRC_TX_EMPTY] = tx_empty; // RQ10
    src_set[`SFID_SRC_TX_OVF] = tx_wr_valid_i && !tx_if.wr_ready; // RQ12
    src_set[`SFID_SRC_TX_UDF] = master_mode_i ?
                                (tx_empty && !shift_busy_i) :
                                slave_udf_evt; // RQ13
    src_set[`SFID_SRC_TX_LVL] = tx_if.count < tx_level_i; // RQ14
    src_set[`SFID_SRC_BUS_ERR] = bus_err_evt;
    src_set[`SFID_SRC_RX_NOT_EMPTY] = rxb_if.rd_valid; // RQ16
    src_set[`SFID_SRC_RX_FULL] = rx_full; // RQ16
    src_set[`SFID_SRC_RX_OVF] = rx_wr_valid_i && !rx_if.wr_ready; // RQ17
    src_set[`SFID_SRC_RX_UDF] = rx_rd_ready_i && !rxb_if.rd_valid; // RQ18
    src_set[`SFID_SRC_RX_LVL] = rx_if.count > rx_level_i; // RQ19
  end

  // A set in the clearing cycle wins, so levels re-set and no event is lost
  assign nxt_src = src_set | (src_ff & ~src_clr_i); // RQ20 RQ21

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      src_ff <= `SFID_SRC_RST;
    end else begin
      src_ff <= nxt_src;
    end
  end

  assign src_status_o = src_ff;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(src_ff & irq_en_i); // RQ5 RQ22
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_dma_request_o <= 1'b0;
      rx_dma_request_o <= 1'b0;
    end else begin
      tx_dma_request_o <= tx_if.count < tx_level_i; // RQ7
      rx_dma_request_o <= rx_if.count > rx_level_i; // RQ6
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_SS_POLARITY: assert property ( // RQ1
    !ti_precede_i && !ss_polarity_i[1] && !ss_active_i[1]
    |=> slave_select_lines_o[1])
    else $error("Idle active-low select line is not high");

  AST_SS_TI_INVERT: assert property ( // RQ2
    ti_precede_i && !ss_polarity_i[0] && !ss_active_i[0]
    |=> !slave_select_lines_o[0])
    else $error("Frame-pulse select line does not idle low");

  AST_TX_DMA: assert property ( // RQ7
    tx_if.count < tx_level_i |=> tx_dma_request_o)
    else $error("Transmit DMA request missing below threshold");

  AST_RX_DMA: assert property ( // RQ6
    rx_if.count <= rx_level_i |=> !rx_dma_request_o)
    else $error("Receive DMA request active at or below threshold");

  AST_TX_OVF: assert property ( // RQ12
    tx_wr_valid_i && tx_if.count == cap
    |=> src_status_o[`SFID_SRC_TX_OVF] ##1 irq_o || !irq_en_i[3])
    else $error("Write to full transmit FIFO not flagged");

  AST_RX_OVF_STICKY: assert property ( // RQ21
    src_status_o[`SFID_SRC_RX_OVF] && !src_clr_i[`SFID_SRC_RX_OVF]
    |=> src_status_o[`SFID_SRC_RX_OVF])
    else $error("Receive overflow dropped without a clear");

  AST_RX_UDF: assert property ( // RQ18
    rx_rd_ready_i && !rx_rd_valid_o |=> src_status_o[`SFID_SRC_RX_UDF])
    else $error("Read of empty receive FIFO not flagged");

  AST_LEVEL_RESET: assert property ( // RQ20
    src_clr_i[`SFID_SRC_TX_EMPTY] && tx_empty
    |=> src_status_o[`SFID_SRC_TX_EMPTY])
    else $error("Transmit-empty cleared while the FIFO is empty");

  AST_IRQ_GATE: assert property ( // RQ22
    (src_ff & irq_en_i) == '0 |=> !irq_o)
    else $error("Interrupt raised with no enabled source");

  AST_DONE: assert property ( // RQ8
    done_evt |=> src_status_o[`SFID_SRC_DONE])
    else $error("Transfer done not latched");

  AST_TX_NOT_FULL: assert property ( // RQ11
    tx_if.count < cap |=> src_status_o[`SFID_SRC_TX_NOT_FULL])
    else $error("Transmit-not-full missing while space remains");

  AST_TX_EMPTY: assert property ( // RQ10
    tx_if.count == '0 |=> src_status_o[`SFID_SRC_TX_EMPTY])
    else $error("Transmit-empty missing with an empty FIFO");

  AST_TX_LVL: assert property ( // RQ14
    tx_if.count < tx_level_i |=> src_status_o[`SFID_SRC_TX_LVL])
    else $error("Transmit level source missing below threshold");

  AST_TX_UDF_MASTER: assert property ( // RQ13
    master_mode_i && tx_if.count == '0 && !shift_busy_i
    |=> src_status_o[`SFID_SRC_TX_UDF])
    else $error("Master underflow missing with nothing to send");

  AST_RX_NOT_EMPTY: assert property ( // RQ16
    rx_rd_valid_o |=> src_status_o[`SFID_SRC_RX_NOT_EMPTY])
    else $error("Receive-not-empty missing with data readable");

  AST_RX_OVF: assert property ( // RQ17
    rx_wr_valid_i && rx_if.count == cap
    |=> src_status_o[`SFID_SRC_RX_OVF])
    else $error("Write into full receive FIFO not flagged");

  AST_RX_LVL: assert property ( // RQ19
    rx_if.count > rx_level_i |=> src_status_o[`SFID_SRC_RX_LVL])
    else $error("Receive level source missing above threshold");

  COV_DONE: cover property (done_evt);
  COV_TX_FULL: cover property (tx_wr_valid_i && tx_if.count == cap);
  COV_RX_STALL: cover property (rx_full && !rx_rd_ready_i);
  COV_BUS_ERR: cover property (bus_err_evt);
  COV_SLAVE_UDF: cover property (slave_udf_evt);
endmodule
`default_nettype wire

// [tb/sfid_spi_master_model.sv]
// Behavioural external SPI master that frames the slave-mode link
`timescale 1ns/1ps
`default_nettype none
module sfid_spi_master_model (
  output logic sclk_o, // Serial clock, idles at its resting level
  output logic ss_b_o // Select, active low, pulled up when released
);
  initial begin
    sclk_o = 1'b0;
    ss_b_o = 1'b1;
  end
  // Clock only inside a frame; a short frame mimics a mid-transfer abort
  task automatic frame(input int nbits);
    #7;
    ss_b_o = 1'b0;
    #160;
    repeat (nbits) begin
      sclk_o = 1'b1;
      #80;
      sclk_o = 1'b0;
      #80;
    end
    #160;
    ss_b_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb/spi_fifo_irq_dma_triggers_tb_top.sv]
// Self-checking bench of the SPI FIFO, interrupt and DMA-trigger block
`timescale 1ns/1ps
`default_nettype none
`include "sfid_params.svh"
module spi_fifo_irq_dma_triggers_tb_top;
  import sfid_pkg::*;
  logic clk_sys_i, rst_b_i = 1'b0, master = 1'b1, byte_m = 1'b0;
  logic ti = 1'b0, tx_wv = 1'b0, tx_rr = 1'b0, busy = 1'b0;
  logic rx_wv = 1'b0, rx_rr = 1'b0, irq, txdma, rxdma, tx_rv, rx_rv;
  logic [3:0] ss_pol = 4'h0, ss_act = 4'h0, ssl;
  logic [4:0] fbits = 5'h08, tx_lvl = 5'h00, rx_lvl = 5'h00;
  logic [15:0] tx_wd = 16'h0000, rx_wd = 16'h0000, tx_rd, rx_rd;
  logic [11:0] irq_en = 12'h000, clr = 12'h000;
  sfid_src_type st;
  wire logic sclk, ss_b;
  int failures = 0, checked = 0, cyc = 0;
  sfid_spi_master_model mst (.sclk_o(sclk), .ss_b_o(ss_b));
  sfid_top dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .master_mode_i(master), .byte_mode_i(byte_m), .ti_precede_i(ti),
    .cpol_i(1'b0), .ss_polarity_i(ss_pol), .frame_bits_i(fbits),
    .ss_active_i(ss_act), .slave_select_lines_o(ssl),
    .spi_sclk_i(sclk), .spi_ss_i(ss_b), .tx_wr_valid_i(tx_wv),
    .tx_wr_data_i(tx_wd), .tx_rd_valid_o(tx_rv), .tx_rd_data_o(tx_rd),
    .tx_rd_ready_i(tx_rr), .shift_busy_i(busy), .rx_wr_valid_i(rx_wv),
    .rx_wr_data_i(rx_wd), .rx_rd_valid_o(rx_rv), .rx_rd_data_o(rx_rd),
    .rx_rd_ready_i(rx_rr), .tx_level_i(tx_lvl), .rx_level_i(rx_lvl),
    .irq_en_i(irq_en), .src_clr_i(clr), .src_status_o(st),
    .irq_o(irq), .tx_dma_request_o(txdma), .rx_dma_request_o(rxdma));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_of_test();
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run needs well under this many cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // Checks land 1 ns after an edge so registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic clear(input logic [11:0] bits);
    @(posedge clk_sys_i) clr <= bits;
    @(posedge clk_sys_i) clr <= 12'h000;
    settle(2);
  endtask
  task automatic t_reset();
    settle(2);
    chk("select", 16'h000F, {12'h000, ssl});
    chk("status", 16'h0016, {4'h0, st});
    chk("txdma", 16'h0000, {15'h0, txdma});
  endtask
  task automatic t_select();
    logic [3:0] e;
    for (int t = 0; t < 2; t++) begin
      @(posedge clk_sys_i);
      // Four lines cover every mix of polarity and request
      ss_pol <= 4'b1010;
      ss_act <= 4'b0110;
      ti <= t[0];
      settle(2);
      e = t[0] ? 4'b1100 : 4'b0011;
      chk("select", {12'h000, e}, {12'h000, ssl});
    end
    @(posedge clk_sys_i);
    ss_pol <= 4'h0;
    ss_act <= 4'h0;
    ti <= 1'b0;
  endtask
  task automatic t_tx(input logic bm, input int depth);
    logic [15:0] v;
    @(posedge clk_sys_i) byte_m <= bm;
    tx_lvl <= 5'd4;
    settle(3);
    chk("txdma", 16'h0001, {15'h0, txdma});
    chk("tx_lvl", 16'h1, {15'h0, st[`SFID_SRC_TX_LVL]});
    for (int i = 0; i < depth; i++) begin
      @(posedge clk_sys_i) tx_wv <= 1'b1;
      tx_wd <= 16'hA500 + 16'(i);
    end
    @(posedge clk_sys_i) tx_wd <= 16'hBEEF;
    @(posedge clk_sys_i) tx_wv <= 1'b0;
    settle(2);
    // Level sources stay latched until cleared; clear them while full
    clear(12'h026);
    chk("tx_not_full", 16'h0, {15'h0, st[`SFID_SRC_TX_NOT_FULL]});
    chk("tx_empty", 16'h0, {15'h0, st[`SFID_SRC_TX_EMPTY]});
    chk("tx_lvl", 16'h0, {15'h0, st[`SFID_SRC_TX_LVL]});
    chk("txdma", 16'h0000, {15'h0, txdma});
    chk("tx_ovf", 16'h1, {15'h0, st[`SFID_SRC_TX_OVF]});
    for (int i = 0; i < depth; i++) begin
      v = 16'hA500 + 16'(i);
      chk("tx_head", bm ? {8'h00, v[7:0]} : v, tx_rd);
      @(posedge clk_sys_i) tx_rr <= 1'b1;
      @(posedge clk_sys_i) tx_rr <= 1'b0;
      #1;
    end
    settle(2);
    chk("tx_valid", 16'h0, {15'h0, tx_rv});
    chk("tx_empty", 16'h1, {15'h0, st[`SFID_SRC_TX_EMPTY]});
    chk("tx_lvl", 16'h1, {15'h0, st[`SFID_SRC_TX_LVL]});
    chk("tx_ovf", 16'h1, {15'h0, st[`SFID_SRC_TX_OVF]});
    clear(12'h00C);
    chk("tx_ovf", 16'h0, {15'h0, st[`SFID_SRC_TX_OVF]});
    chk("tx_empty", 16'h1, {15'h0, st[`SFID_SRC_TX_EMPTY]});
    @(posedge clk_sys_i) byte_m <= 1'b0;
  endtask
  task automatic t_rx();
    @(posedge clk_sys_i) rx_lvl <= 5'd3;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys_i) rx_wv <= 1'b1;
      rx_wd <= 16'h5A00 + 16'(i);
    end
    @(posedge clk_sys_i) rx_wv <= 1'b0;
    settle(3);
    chk("rx_full", 16'h1, {15'h0, st[`SFID_SRC_RX_FULL]});
    chk("rx_ovf", 16'h1, {15'h0, st[`SFID_SRC_RX_OVF]});
    chk("rx_lvl", 16'h1, {15'h0, st[`SFID_SRC_RX_LVL]});
    chk("rxdma", 16'h1, {15'h0, rxdma});
    for (int i = 0; i < 10; i++) begin
      chk("rx_data", 16'h5A00 + 16'(i), rx_rd);
      @(posedge clk_sys_i) rx_rr <= 1'b1;
      @(posedge clk_sys_i) rx_rr <= 1'b0;
      settle(2);
    end
    clear(12'h980);
    chk("rx_not_empty", 16'h0, {15'h0, st[`SFID_SRC_RX_NOT_EMPTY]});
    chk("rx_valid", 16'h0, {15'h0, rx_rv});
    chk("rx_full", 16'h0, {15'h0, st[`SFID_SRC_RX_FULL]});
    chk("rxdma", 16'h0, {15'h0, rxdma});
    @(posedge clk_sys_i) rx_rr <= 1'b1;
    @(posedge clk_sys_i) rx_rr <= 1'b0;
    settle(2);
    chk("rx_udf", 16'h1, {15'h0, st[`SFID_SRC_RX_UDF]});
    clear(12'h600);
  endtask
  task automatic t_irq();
    @(posedge clk_sys_i) irq_en <= 12'h004;
    settle(3);
    chk("irq", 16'h1, {15'h0, irq});
    @(posedge clk_sys_i) irq_en <= 12'h008;
    settle(3);
    chk("irq", 16'h0, {15'h0, irq});
    @(posedge clk_sys_i) irq_en <= 12'h000;
  endtask
  task automatic t_done();
    @(posedge clk_sys_i) busy <= 1'b1;
    settle(2);
    chk("done", 16'h0, {15'h0, st[`SFID_SRC_DONE]});
    @(posedge clk_sys_i) busy <= 1'b0;
    settle(3);
    chk("done", 16'h1, {15'h0, st[`SFID_SRC_DONE]});
    clear(12'h001);
  endtask
  task automatic t_slave();
    @(posedge clk_sys_i) master <= 1'b0;
    clear(12'h050);
    chk("tx_udf", 16'h0, {15'h0, st[`SFID_SRC_TX_UDF]});
    mst.frame(8);
    settle(4);
    chk("tx_udf", 16'h1, {15'h0, st[`SFID_SRC_TX_UDF]});
    chk("bus_err", 16'h0, {15'h0, st[`SFID_SRC_BUS_ERR]});
    mst.frame(3);
    settle(4);
    chk("bus_err", 16'h1, {15'h0, st[`SFID_SRC_BUS_ERR]});
    clear(12'h050);
    @(posedge clk_sys_i) master <= 1'b1;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_select();
    t_tx(1'b0, `SFID_WORD_DEPTH);
    t_tx(1'b1, `SFID_BYTE_DEPTH);
    t_rx();
    t_irq();
    t_done();
    t_slave();
    end_of_test();
  end
endmodule
`default_nettype wire
